// [rtl/position_event_capture_readout.sv]
// Registration capture readout: manual events and automated pulse frames.
// Assumes the registration input and position are sampled once per update
// cycle, signalled by update_en_i, and the reader issues one read at a time.
`default_nettype none
module position_event_capture_readout (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          update_en_i,
    input  wire logic                          reg_input_i,
    input  wire logic [capture_pkg::POS_W-1:0] position_i,
    input  wire logic                          capture_on_i,
    input  wire logic                          auto_mode_i,
    input  wire capture_pkg::capture_kind_t    capture_kind_i,
    input  wire logic [capture_pkg::CNT_W-1:0] report_pulses_i,
    input  wire capture_pkg::report_format_t   report_format_i,
    input  wire logic [capture_pkg::ELEM_AW:0] array_size_i,
    input  wire logic                          read_single_event_i,
    output logic [1:0]                         event_status_o,
    output logic [2:0]                         event_type_code_o,
    output logic [capture_pkg::POS_W-1:0]      first_edge_position_o,
    output logic [capture_pkg::POS_W-1:0]      width_or_gap_o,
    output logic [capture_pkg::POS_W-1:0]      second_edge_position_o,
    input  wire logic                          read_pattern_frame_i,
    output logic [1:0]                         frame_status_o,
    output logic [capture_pkg::CNT_W-1:0]      complete_pulse_count_o,
    output logic                               frame_result_valid_o,
    output logic [capture_pkg::ELEM_AW-1:0]    frame_result_index_o,
    output logic [capture_pkg::POS_W-1:0]      frame_result_array_o
);
    // ------------------------------------------------------------
    // Input edge detection
    // ------------------------------------------------------------
    logic                          prev_in_reg;
    logic                          armed_reg;
    logic                          on_reg;
    logic                          have_edge_reg;
    logic [capture_pkg::POS_W-1:0] last_edge_reg;
    logic                          in_pulse_reg;
    logic [capture_pkg::POS_W-1:0] pulse_start_reg;
    logic                          fall;
    logic                          rise;
    logic                          restart;
    logic                          neg_kind;

    assign fall    = update_en_i && armed_reg && prev_in_reg && !reg_input_i;
    assign rise    = update_en_i && armed_reg && !prev_in_reg && reg_input_i;
    assign restart = capture_on_i && !on_reg;

    // automated kinds use pulse polarity only
    assign neg_kind = auto_mode_i ? (capture_kind_i != capture_pkg::KIND_POS_PULSE)
                                  : (capture_kind_i == capture_pkg::KIND_NEG_PULSE);

    // ------------------------------------------------------------
    // Manual event builder
    // ------------------------------------------------------------
    logic                    pulse_start;
    logic                    pulse_end;
    logic                    edge_hit;
    logic                    man_push;
    capture_pkg::event_rec_t man_rec;
    logic [capture_pkg::POS_W-1:0] gap;

    assign pulse_start = neg_kind ? fall : rise;
    assign pulse_end   = in_pulse_reg && (neg_kind ? rise : fall);
    assign edge_hit = (capture_kind_i == capture_pkg::KIND_NEG_EDGE  && fall) ||
                      (capture_kind_i == capture_pkg::KIND_POS_EDGE  && rise) ||
                      (capture_kind_i == capture_pkg::KIND_BOTH_EDGE && (fall || rise));
    assign man_push = !auto_mode_i && on_reg &&
                      (edge_hit || (pulse_end &&
                       (capture_kind_i == capture_pkg::KIND_NEG_PULSE ||
                        capture_kind_i == capture_pkg::KIND_POS_PULSE)));
    assign gap = have_edge_reg ? (position_i - last_edge_reg) : '0;

    // Record fields for the event being pushed
    always_comb begin
        man_rec = '0;
        if (edge_hit) begin
            man_rec.code = fall ? capture_pkg::CODE_NEG_EDGE : capture_pkg::CODE_POS_EDGE;
            man_rec.first_pos = position_i;
            man_rec.width_gap = gap;
            man_rec.second_pos = '0;
        end else begin
            man_rec.code = neg_kind ? capture_pkg::CODE_NEG_PULSE
                                    : capture_pkg::CODE_POS_PULSE;
            man_rec.first_pos = pulse_start_reg;
            man_rec.width_gap = position_i - pulse_start_reg;
            man_rec.second_pos = position_i;
        end
    end

    // Edge and pulse history; armed, edge and pulse flags cleared when capture restarts or is off
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_in_reg     <= 1'b0;
            armed_reg       <= 1'b0;
            on_reg          <= 1'b0;
            have_edge_reg   <= 1'b0;
            last_edge_reg   <= '0;
            in_pulse_reg    <= 1'b0;
            pulse_start_reg <= '0;
        end else begin
            on_reg <= capture_on_i;
            if (restart || !capture_on_i) begin
                armed_reg     <= 1'b0;
                have_edge_reg <= 1'b0;
                in_pulse_reg  <= 1'b0;
            end else if (update_en_i) begin
                prev_in_reg <= reg_input_i;
                armed_reg   <= 1'b1;
                if (edge_hit) begin
                    have_edge_reg <= 1'b1;
                    last_edge_reg <= position_i;
                end
                if (pulse_start) begin
                    in_pulse_reg    <= 1'b1;
                    pulse_start_reg <= position_i;
                end else if (pulse_end) begin
                    in_pulse_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Manual event ring and single-event read
    // ------------------------------------------------------------
    logic                    ring_ne;
    logic                    ring_over;
    capture_pkg::event_rec_t ring_head;
    logic                    single_ok;

    event_ring u_ring (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .clear_i     (restart),
        .push_i      (man_push),
        .push_data_i (man_rec),
        .pop_i       (read_single_event_i),
        .not_empty_o (ring_ne),
        .overrun_o   (ring_over),
        .head_o      (ring_head)
    );

    assign single_ok = read_single_event_i && ring_ne;

    // Read answer registered; zeros whenever nothing is delivered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_status_o         <= capture_pkg::ST_NONE;
            event_type_code_o      <= capture_pkg::CODE_NONE;
            first_edge_position_o  <= '0;
            width_or_gap_o         <= '0;
            second_edge_position_o <= '0;
        end else if (single_ok) begin
            event_status_o         <= ring_over ? capture_pkg::ST_OVER : capture_pkg::ST_NEW;
            event_type_code_o      <= ring_head.code;
            first_edge_position_o  <= ring_head.first_pos;
            width_or_gap_o         <= ring_head.width_gap;
            second_edge_position_o <= ring_head.second_pos;
        end else begin
            event_status_o         <= capture_pkg::ST_NONE;
            event_type_code_o      <= capture_pkg::CODE_NONE;
            first_edge_position_o  <= '0;
            width_or_gap_o         <= '0;
            second_edge_position_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // Automated frame collection
    // ------------------------------------------------------------
    capture_pkg::pulse_rec_t     frame_reg [capture_pkg::FRAME_MAX];
    logic [capture_pkg::CNT_W-1:0] fill_cnt_reg;
    logic [capture_pkg::CNT_W-1:0] ready_cnt_reg;
    logic                          frame_new_reg;
    logic                          auto_end;
    logic                          frame_done;
    logic                          dump_busy;

    assign auto_end   = auto_mode_i && on_reg && pulse_end;
    // count range kept by the caller
    assign frame_done = auto_end && (fill_cnt_reg + 9'h001 >= report_pulses_i);

    // Pulse storage by index
    always_ff @(posedge clk_i) begin
        if (auto_end) begin
            frame_reg[fill_cnt_reg[capture_pkg::BUF_AW-1:0]] <=
                '{pos: pulse_start_reg, width: position_i - pulse_start_reg};
        end
    end

    // Frame fill counter and completion flag; a new frame wins over a read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_cnt_reg  <= '0;
            ready_cnt_reg <= '0;
            frame_new_reg <= 1'b0;
        end else if (restart) begin
            fill_cnt_reg  <= '0;
            frame_new_reg <= 1'b0;
        end else if (frame_done) begin
            fill_cnt_reg  <= '0;
            ready_cnt_reg <= fill_cnt_reg + 9'h001;
            frame_new_reg <= 1'b1;
        end else begin
            if (auto_end) begin
                fill_cnt_reg <= fill_cnt_reg + 9'h001;
            end
            if (read_pattern_frame_i && !dump_busy) begin
                frame_new_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame dump: one element per clock onto the result port
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        DUMP_IDLE = 1'b0,
        DUMP_RUN  = 1'b1
    } dump_state_t;

    dump_state_t                   dump_state_reg;
    logic [capture_pkg::CNT_W-1:0] pulse_idx_reg;
    logic [1:0]                    sub_idx_reg;
    logic [capture_pkg::CNT_W-1:0] sets_fit;
    logic [capture_pkg::CNT_W-1:0] sets_done;
    logic [capture_pkg::ELEM_AW-1:0] per_set;
    logic [capture_pkg::ELEM_AW:0] elems_need;
    logic [1:0]                    last_sub;
    capture_pkg::pulse_rec_t       cur_p;
    capture_pkg::pulse_rec_t       prev_p;
    capture_pkg::pulse_rec_t       first_p;
    logic [capture_pkg::POS_W-1:0] rel_frame;
    logic [capture_pkg::POS_W-1:0] rel_prev;
    logic [capture_pkg::POS_W-1:0] elem_val;
    logic                          first_pulse;
    logic                          set_last;

    assign dump_busy = (dump_state_reg == DUMP_RUN);
    // four elements per pulse in format 3
    assign per_set   = (report_format_i == capture_pkg::FMT_ALL_VIEWS)
                       ? capture_pkg::ELEMS_FOUR : capture_pkg::ELEMS_TWO;
    assign last_sub  = 2'(per_set - 10'h001);
    assign elems_need = 11'(ready_cnt_reg) * 11'(per_set);
    // whole sets that fit the array
    assign sets_fit  = (array_size_i >= elems_need) ? ready_cnt_reg
                       : 9'((per_set == capture_pkg::ELEMS_FOUR) ? (array_size_i >> 2)
                                                                 : (array_size_i >> 1));
    assign cur_p     = frame_reg[pulse_idx_reg[capture_pkg::BUF_AW-1:0]];
    assign prev_p    = frame_reg[8'(pulse_idx_reg - 9'h001)];
    assign first_p   = frame_reg[0];
    assign first_pulse = (pulse_idx_reg == 9'h000);
    assign rel_frame = first_pulse ? cur_p.pos : (cur_p.pos - first_p.pos);
    assign rel_prev  = first_pulse ? cur_p.pos : (cur_p.pos - prev_p.pos);
    assign set_last  = (sub_idx_reg == last_sub);
    assign sets_done = sets_fit;

    // Element selection per format
    always_comb begin
        elem_val = cur_p.width;
        unique case (report_format_i)
            capture_pkg::FMT_ABSOLUTE:
                elem_val = (sub_idx_reg == 2'h0) ? cur_p.pos : cur_p.width;
            capture_pkg::FMT_FRAME_REL:
                elem_val = (sub_idx_reg == 2'h0) ? rel_frame : cur_p.width;
            capture_pkg::FMT_PULSE_REL:
                elem_val = (sub_idx_reg == 2'h0) ? rel_prev : cur_p.width;
            capture_pkg::FMT_ALL_VIEWS: begin
                unique case (sub_idx_reg)
                    2'h0: elem_val = cur_p.pos;
                    2'h1: elem_val = rel_frame;
                    2'h2: elem_val = rel_prev;
                    2'h3: elem_val = cur_p.width;
                endcase
            end
        endcase
    end

    // Dump sequencer and frame read answer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dump_state_reg         <= DUMP_IDLE;
            pulse_idx_reg          <= '0;
            sub_idx_reg            <= '0;
            frame_status_o         <= capture_pkg::ST_NONE;
            complete_pulse_count_o <= '0;
            frame_result_valid_o   <= 1'b0;
            frame_result_index_o   <= '0;
            frame_result_array_o   <= '0;
        end else begin
            frame_result_valid_o <= 1'b0;
            unique case (dump_state_reg)
                DUMP_IDLE: begin
                    if (read_pattern_frame_i) begin
                        // status 1 new, 0 leaves data alone
                        if (frame_new_reg && sets_done != 9'h000) begin
                            dump_state_reg <= DUMP_RUN;
                            frame_status_o <= (sets_fit == ready_cnt_reg)
                                              ? capture_pkg::ST_NEW : capture_pkg::ST_OVER;
                            complete_pulse_count_o <= sets_done;
                        end else if (frame_new_reg) begin
                            frame_status_o         <= capture_pkg::ST_OVER;
                            complete_pulse_count_o <= '0;
                        end else begin
                            frame_status_o <= capture_pkg::ST_NONE;
                        end
                        pulse_idx_reg <= '0;
                        sub_idx_reg   <= '0;
                    end
                end
                DUMP_RUN: begin
                    frame_result_valid_o <= 1'b1;
                    frame_result_index_o <= 10'(pulse_idx_reg) * per_set
                                            + 10'(sub_idx_reg);
                    frame_result_array_o <= elem_val;
                    if (set_last) begin
                        sub_idx_reg   <= '0;
                        pulse_idx_reg <= pulse_idx_reg + 9'h001;
                        if (pulse_idx_reg + 9'h001 == sets_done) begin
                            dump_state_reg <= DUMP_IDLE;
                        end
                    end else begin
                        sub_idx_reg <= sub_idx_reg + 2'h1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [rtl/capture_pkg.sv]
// Shared types and constants for the position event capture readout.
// Assumes a single clock domain and synchronous inputs.
`default_nettype none
package capture_pkg;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int unsigned POS_W      = 32;
    localparam int unsigned BUF_DEPTH  = 256;
    localparam int unsigned BUF_AW     = 8;
    localparam int unsigned FRAME_MAX  = 256;
    localparam int unsigned CNT_W      = 9;
    localparam int unsigned ELEM_AW    = 10;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_NEG_PULSE = 3'h0,
        KIND_POS_PULSE = 3'h1,
        KIND_NEG_EDGE  = 3'h2,
        KIND_POS_EDGE  = 3'h3,
        KIND_BOTH_EDGE = 3'h4
    } capture_kind_t;

    localparam logic [2:0] CODE_NONE      = 3'h0;
    localparam logic [2:0] CODE_NEG_EDGE  = 3'h1;
    localparam logic [2:0] CODE_POS_EDGE  = 3'h2;
    localparam logic [2:0] CODE_NEG_PULSE = 3'h3;
    localparam logic [2:0] CODE_POS_PULSE = 3'h4;

    localparam logic [1:0] ST_NONE = 2'h0;
    localparam logic [1:0] ST_NEW  = 2'h1;
    localparam logic [1:0] ST_OVER = 2'h2;

    typedef enum logic [1:0] {
        FMT_ABSOLUTE  = 2'h0,
        FMT_FRAME_REL = 2'h1,
        FMT_PULSE_REL = 2'h2,
        FMT_ALL_VIEWS = 2'h3
    } report_format_t;

    localparam logic [ELEM_AW-1:0] ELEMS_TWO  = 10'h002;
    localparam logic [ELEM_AW-1:0] ELEMS_FOUR = 10'h004;

    // One stored manual event
    typedef struct packed {
        logic [2:0]       code;
        logic [POS_W-1:0] first_pos;
        logic [POS_W-1:0] width_gap;
        logic [POS_W-1:0] second_pos;
    } event_rec_t;

    // One pulse of an automated frame
    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] width;
    } pulse_rec_t;
endpackage
`default_nettype wire

// [rtl/event_ring.sv]
// Circular store of manual capture events with overwrite tracking.
// Assumes one push and one pop request at most per clock.
`default_nettype none
module event_ring (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clear_i,
    input  wire logic                   push_i,
    input  wire capture_pkg::event_rec_t push_data_i,
    input  wire logic                   pop_i,
    output logic                        not_empty_o,
    output logic                        overrun_o,
    output capture_pkg::event_rec_t     head_o
);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    capture_pkg::event_rec_t mem_reg [capture_pkg::BUF_DEPTH];
    logic [capture_pkg::BUF_AW-1:0] wr_ptr_reg;
    logic [capture_pkg::BUF_AW-1:0] rd_ptr_reg;
    logic [capture_pkg::BUF_AW:0]   fill_reg;
    logic                           over_reg;
    logic                           full;
    logic                           do_pop;

    assign full        = (fill_reg == 9'(capture_pkg::BUF_DEPTH));
    assign not_empty_o = (fill_reg != 9'h000);
    assign overrun_o   = over_reg;
    assign head_o      = mem_reg[rd_ptr_reg];
    assign do_pop      = pop_i && not_empty_o;

    // Entry writes; no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push_i) begin
            mem_reg[wr_ptr_reg] <= push_data_i;
        end
    end

    // Pointer update; a push into a full ring drops the oldest entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
            over_reg   <= 1'b0;
        end else if (clear_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
            over_reg   <= 1'b0;
        end else begin
            if (push_i) begin
                wr_ptr_reg <= wr_ptr_reg + 8'h01;
            end
            if (push_i && full) begin
                rd_ptr_reg <= rd_ptr_reg + 8'h01;
                over_reg   <= 1'b1;
            end else if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 8'h01;
                over_reg   <= 1'b0;
            end
            if (push_i && !full && !do_pop) begin
                fill_reg <= fill_reg + 9'h001;
            end else if (!push_i && do_pop) begin
                fill_reg <= fill_reg - 9'h001;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/capture_readout_asserts.sv]
// Port checks for the capture readout.
// Assumes one clock, reset low while asserted.
`default_nettype none
module capture_readout_asserts (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        read_single_event_i,
    input wire logic [1:0]  event_status_o,
    input wire logic [2:0]  event_type_code_o,
    input wire logic [31:0] first_edge_position_o,
    input wire logic [31:0] width_or_gap_o,
    input wire logic [31:0] second_edge_position_o,
    input wire logic        read_pattern_frame_i,
    input wire logic [1:0]  frame_status_o,
    input wire logic [8:0]  complete_pulse_count_o,
    input wire logic        frame_result_valid_o,
    input wire logic [9:0]  frame_result_index_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Frame read taken while idle, then its status
    sequence s_new;
        read_pattern_frame_i && !frame_result_valid_o ##1 frame_status_o == 2'h1;
    endsequence
    sequence s_none;
        read_pattern_frame_i && !frame_result_valid_o ##1 frame_status_o == 2'h0;
    endsequence
    chk_idle_data_zero:
    assert property (event_status_o == 2'h0 |-> {event_type_code_o, first_edge_position_o,
        width_or_gap_o, second_edge_position_o} == 99'h0) else $error("data not zero");
    chk_status_one_cycle:
    assert property (!read_single_event_i |=> event_status_o == 2'h0) else $error("stray status");
    chk_type_code_range:
    assert property (event_status_o != 2'h0 |-> event_type_code_o inside {[3'h1:3'h4]})
        else $error("bad type code");
    chk_edge_trail_zero:
    assert property (event_status_o != 2'h0 && event_type_code_o <= 3'h2
        |-> second_edge_position_o == 32'h0) else $error("edge trail not zero");
    chk_pulse_width_span:
    assert property (event_status_o != 2'h0 && event_type_code_o >= 3'h3
        |-> width_or_gap_o == second_edge_position_o - first_edge_position_o)
        else $error("width mismatch");
    chk_frame_status_hold:
    assert property (!read_pattern_frame_i |=> $stable(frame_status_o)
        && $stable(complete_pulse_count_o)) else $error("frame status moved");
    chk_no_stream_stale:
    assert property (s_none |=> !frame_result_valid_o [*3]) else $error("stale frame streamed");
    chk_first_element:
    assert property (s_new |=> frame_result_valid_o && frame_result_index_o == 10'h000)
        else $error("first element late");
endmodule
bind position_event_capture_readout capture_readout_asserts u_chk (.*);
`default_nettype wire

// [verif/result_reader.sv]
// Polling reader model on the far side of the single-event read.
// Assumes the bench calls fetch once at a time.
`default_nettype none
module result_reader (
    input  wire logic        clk_i,
    output logic             read_o,
    input  wire logic [1:0]  status_i,
    input  wire logic [98:0] data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial read_o = 1'b0;
    // results used in the answer cycle only, since they drop next cycle
    task automatic fetch(output logic [1:0] st, output logic [98:0] d);
        @(posedge clk_i) read_o <= 1'b1;
        @(posedge clk_i) read_o <= 1'b0;
        @(negedge clk_i) st = status_i;
        d = data_i;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the capture readout.
// Assumes the package, design, reader model and checker compiled before.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, upd = 0, lvl = 1, on = 0, auto = 0, rd_fr = 0, rd_ev, fv;
    logic [31:0] pos = 0, p1, gap, p2, fdat;
    logic [1:0] fmt = 0, st, fst, s;
    logic [10:0] size = 0;
    logic [2:0] kind = 0, code;
    logic [8:0] cnt;
    logic [9:0] fidx;
    logic [98:0] d;
    int failures = 0, compares = 0;
    initial forever #20 clk = ~clk;
    // three reported pulses, inside the legal range
    position_event_capture_readout u_position_event_capture_readout (.clk_i(clk), .rst_n_i(rst_n),
        .update_en_i(upd), .reg_input_i(lvl), .position_i(pos), .capture_on_i(on),
        .auto_mode_i(auto), .capture_kind_i(capture_pkg::capture_kind_t'(kind)),
        .report_pulses_i(9'h003), .report_format_i(capture_pkg::report_format_t'(fmt)),
        .array_size_i(size), .read_single_event_i(rd_ev), .event_status_o(st),
        .event_type_code_o(code), .first_edge_position_o(p1), .width_or_gap_o(gap),
        .second_edge_position_o(p2), .read_pattern_frame_i(rd_fr), .frame_status_o(fst),
        .complete_pulse_count_o(cnt), .frame_result_valid_o(fv),
        .frame_result_index_o(fidx), .frame_result_array_o(fdat));
    result_reader u_result_reader (.clk_i(clk), .read_o(rd_ev), .status_i(st),
        .data_i({code, p1, gap, p2}));
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step(input logic l, input logic [31:0] p);
        @(posedge clk) {upd, lvl, pos} <= {1'b1, l, p};
        @(posedge clk) upd <= 1'b0;
    endtask
    // Off then on, so history and ring start clean
    task automatic restart(input logic [2:0] k);
        @(posedge clk) {on, kind} <= {1'b0, k};
        @(posedge clk) on <= 1'b1;
    endtask
    task automatic t_kinds;
        logic [98:0] e [5] = '{{3'h3, 32'd20, 32'd15, 32'd35}, {3'h4, 32'd35, 32'd15, 32'd50},
            {3'h1, 32'd20, 64'd0}, {3'h2, 32'd35, 64'd0}, {3'h1, 32'd20, 64'd0}};
        for (int k = 0; k < 5; k++) begin
            restart(3'(k));
            step(1, 10); step(0, 20); step(1, 35); step(0, 50);
            u_result_reader.fetch(s, d);
            check(s, 2'h1);
            check(d, e[k]);
        end
    endtask
    task automatic t_overrun;
        restart(3'h4);
        for (int i = 0; i < 258; i++) step(i[0], 32'(i * 4));
        u_result_reader.fetch(s, d);
        check({s, d}, {2'h2, 3'h1, 32'd8, 32'd4, 32'd0});
        u_result_reader.fetch(s, d);
        check({s, d}, {2'h1, 3'h2, 32'd12, 32'd4, 32'd0});
    endtask
    task automatic frame_read(input logic [1:0] es, input logic [8:0] ec);
        @(posedge clk) rd_fr <= 1'b1;
        @(posedge clk) rd_fr <= 1'b0;
        @(negedge clk) check({fst, cnt}, {es, ec});
    endtask
    task automatic t_frame(input logic [1:0] f, input logic [10:0] sz, input logic [1:0] es,
                           input logic [8:0] ec, input int ev [12]);
        int n = 0;
        @(posedge clk) {auto, fmt, size} <= {1'b1, f, sz};
        restart(3'h1);
        step(0, 90); step(1, 100); step(0, 110); step(1, 130); step(0, 135);
        step(1, 160); step(0, 170);
        frame_read(es, ec);
        repeat (14) @(negedge clk) if (fv) begin
            check({fidx, fdat}, {10'(n), 32'(ev[n])});
            n++;
        end
        check(n, ec * (f == 2'h3 ? 4 : 2));
        frame_read(2'h0, ec);
    endtask
    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole run needs about 800 cycles
    initial begin
        repeat (8000) @(posedge clk);
        failures++;
        results;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        u_result_reader.fetch(s, d);
        check({s, d}, 101'h0);
        t_kinds;
        t_overrun;
        t_frame(2'h0, 11'h00c, 2'h1, 9'h003, '{100, 10, 130, 5, 160, 10, 0, 0, 0, 0, 0, 0});
        t_frame(2'h1, 11'h00c, 2'h1, 9'h003, '{100, 10, 30, 5, 60, 10, 0, 0, 0, 0, 0, 0});
        t_frame(2'h2, 11'h00c, 2'h1, 9'h003, '{100, 10, 30, 5, 30, 10, 0, 0, 0, 0, 0, 0});
        t_frame(2'h3, 11'h00c, 2'h1, 9'h003, '{100, 100, 100, 10, 130, 30, 30, 5, 160, 60, 30, 10});
        t_frame(2'h3, 11'h005, 2'h2, 9'h001, '{100, 100, 100, 10, 0, 0, 0, 0, 0, 0, 0, 0});
        results;
    end
endmodule
`default_nettype wire
